// ### sp_cycle.sv
`timescale 1ns/1ps
// ============================================================
// One timed bus cycle on the flash pins, read or write
module sp_cycle
  import sp_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              req,
  input  wire logic              wr,
  input  wire logic [15:0]       addr,
  input  wire logic [7:0]        wdata,
  output logic                   ready,
  output logic                   done,
  output logic [7:0]             rdata,
  output sp_pkg::sp_pins_t       pins,
  input  wire logic [7:0]        dq_i
);

  typedef enum logic [1:0] {
    E_IDLE   = 2'b00,
    E_SETUP  = 2'b01,
    E_STROBE = 2'b10,
    E_RECOV  = 2'b11
  } sp_eng_t;

  localparam sp_pins_t PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                                     addr: 16'h0000, dq_o: 8'h00,
                                     dq_oe_n: 1'b1};

  initial begin
    if (ACC_CYC + SYNC_STAGES >= (1 << CNT_W) ||
        WP_CYC >= (1 << CNT_W) || WPH_CYC >= (1 << CNT_W))
      $error("sp_cycle: phase counts exceed counter width");
  end

  function automatic logic [CNT_W-1:0] cyc(input int n);
    return CNT_W'(n - 1);
  endfunction

  sp_eng_t          st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             wr_q, wr_d;
  logic             done_q, done_d;
  logic [7:0]       rdata_q, rdata_d;
  logic [7:0]       sync1_q, sync2_q;
  sp_pins_t         pins_q, pins_d;
  wire              cnt_zero = (cnt_q == '0);

  assign ready = (st_q == E_IDLE);
  assign done  = done_q;
  assign rdata = rdata_q;
  assign pins  = pins_q;

  // Phase sequencing; each phase lasts its count then moves on
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_zero ? cnt_q : cnt_q - 1'b1;
    wr_d    = wr_q;
    done_d  = 1'b0;
    rdata_d = rdata_q;
    pins_d  = pins_q;
    unique case (st_q)
      E_IDLE: begin
        if (req) begin
          st_d           = E_SETUP;
          wr_d           = wr;
          cnt_d          = cyc(AS_CYC);
          pins_d.ce_n    = 1'b0;
          pins_d.oe_n    = 1'b1;
          pins_d.we_n    = 1'b1;
          pins_d.addr    = addr;
          pins_d.dq_o    = wdata;
          pins_d.dq_oe_n = ~wr;
        end
      end
      E_SETUP: begin
        if (cnt_zero) begin
          st_d = E_STROBE;
          // OE never drops while WE is low on a write
          if (wr_q) begin
            cnt_d       = cyc(WP_CYC);
            pins_d.we_n = 1'b0;
          end else begin
            cnt_d       = cyc(ACC_CYC + SYNC_STAGES);
            pins_d.oe_n = 1'b0;
          end
        end
      end
      E_STROBE: begin
        if (cnt_zero) begin
          st_d        = E_RECOV;
          cnt_d       = wr_q ? cyc(WPH_CYC) : cyc(OEHP_CYC);
          pins_d.we_n = 1'b1;
          pins_d.oe_n = 1'b1;
          if (!wr_q) begin
            rdata_d = sync2_q;
          end
        end
      end
      E_RECOV: begin
        // Address and data held here cover both hold times
        if (cnt_zero) begin
          st_d           = E_IDLE;
          done_d         = 1'b1;
          pins_d.ce_n    = 1'b1;
          pins_d.dq_oe_n = 1'b1;
        end
      end
    endcase
  end

  // Data pins come from another timing world: two flops first
  always_ff @(posedge clk) begin
    sync1_q <= dq_i;
    sync2_q <= sync1_q;
  end

  // State registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q    <= E_IDLE;
      cnt_q   <= '0;
      wr_q    <= 1'b0;
      done_q  <= 1'b0;
      rdata_q <= 8'h00;
      pins_q  <= PINS_IDLE;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      wr_q    <= wr_d;
      done_q  <= done_d;
      rdata_q <= rdata_d;
      pins_q  <= pins_d;
    end
  end

endmodule

// ### sp_flash_host.sv
`timescale 1ns/1ps
module sp_flash_host #(
  parameter int          BLC_CYCLES    = sp_pkg::BLC_CYC,
  parameter int          WC_CYCLES     = sp_pkg::WC_CYC,
  parameter logic [14:0] UNLOCK_ADDR_A = 15'h0001,
  parameter logic [14:0] UNLOCK_ADDR_B = 15'h0002,
  parameter logic [7:0]  UNLOCK_DATA_A = 8'h01,
  parameter logic [7:0]  UNLOCK_DATA_B = 8'h02,
  parameter logic [7:0]  CODE_PROG     = 8'h03,
  parameter logic [7:0]  CODE_ID_IN    = 8'h04,
  parameter logic [7:0]  CODE_ID_OUT   = 8'h05
) (
  input  wire logic              MCLK,
  input  wire logic              RSTN,
  input  wire logic              CMD_VALID,
  output logic                   CMD_READY,
  input  wire sp_pkg::sp_op_t    CMD_OP,
  input  wire logic [15:0]       CMD_ADDR,
  input  wire logic              WR_VALID,
  output logic                   WR_READY,
  input  wire logic [7:0]        WR_DATA,
  output logic                   RSP_VALID,
  output sp_pkg::sp_rsp_t        RSP,
  output sp_pkg::sp_pins_t       FL_PINS,
  input  wire logic [7:0]        FL_DQ_I
);
  import sp_pkg::*;

  // ============================================================
  // Sizing and checks
  localparam int TW = $clog2(WC_CYCLES + BLC_CYCLES + 1);
  localparam logic [TW-1:0] BLC_LIMIT = TW'(BLC_CYCLES - LOAD_GUARD);
  localparam logic [TW-1:0] WC_LIMIT  = TW'(WC_CYCLES);

  if (BLC_CYCLES <= LOAD_GUARD || WC_CYCLES < 1) begin : g_chk
    $error("sp_flash_host: byte window shorter than one write");
  end

  typedef enum logic [2:0] {
    M_IDLE   = 3'b000,
    M_UNLOCK = 3'b001,
    M_LOAD   = 3'b010,
    M_POLL   = 3'b011,
    M_IDRD   = 3'b100,
    M_READ   = 3'b101,
    M_FIN    = 3'b110
  } sp_main_t;

  // Unlock word for a sequence step: {address, data}
  function automatic logic [22:0] unlock_word(input sp_seq_t s,
                                              input logic [1:0] k);
    logic [7:0] code;
    code = (s == SEQ_PROG)  ? CODE_PROG :
           (s == SEQ_ID_IN) ? CODE_ID_IN : CODE_ID_OUT;
    unique case (k)
      2'd0:    return {UNLOCK_ADDR_A, UNLOCK_DATA_A};
      2'd1:    return {UNLOCK_ADDR_B, UNLOCK_DATA_B};
      default: return {UNLOCK_ADDR_A, code};
    endcase
  endfunction

  sp_main_t   st_q, st_d;
  sp_seq_t    seq_q, seq_d;
  logic [1:0] step_q, step_d;
  logic [6:0] idx_q, idx_d;
  logic [8:0] sector_q, sector_d;
  logic [15:0] addr_q, addr_d;
  logic       pend_q, pend_d;
  logic       ref_q, ref_d;
  logic       have_ref_q, have_ref_d;
  logic [TW-1:0] tmr_q, tmr_d;
  sp_rsp_t    rsp_q, rsp_d;
  logic       rsp_valid_q, rsp_valid_d;

  logic        eng_ready;
  logic        eng_done;
  logic [7:0]  eng_rdata;
  logic        eng_wr;
  logic [15:0] eng_addr;
  logic [7:0]  eng_wdata;
  logic        want;
  logic        issue;

  // ============================================================
  // Request selection toward the cycle engine
  wire [22:0] uw       = unlock_word(seq_q, step_q);
  wire [15:0] ld_addr  = {sector_q, idx_q};
  wire [15:0] pol_addr = {sector_q, LAST_BYTE};
  wire [15:0] id_addr  = idx_q[0] ? ID_PART_ADDR : ID_MAKER_ADDR;
  wire        in_load  = (st_q == M_LOAD);
  wire        toggle   = eng_rdata[TOGGLE_BIT];

  // Command writes drive A15 low: only A14..A0 carry the code
  assign eng_addr  = (st_q == M_UNLOCK) ? {1'b0, uw[22:8]} :
                     in_load            ? ld_addr :
                     (st_q == M_POLL)   ? pol_addr :
                     (st_q == M_IDRD)   ? id_addr : addr_q;
  assign eng_wdata = (st_q == M_UNLOCK) ? uw[7:0] : WR_DATA;
  assign eng_wr    = (st_q == M_UNLOCK) || in_load;
  assign want      = in_load ? WR_VALID :
                     (st_q != M_IDLE) && (st_q != M_FIN);
  assign issue     = want && eng_ready && !pend_q;
  assign WR_READY  = in_load && eng_ready && !pend_q;
  assign CMD_READY = (st_q == M_IDLE);
  assign RSP_VALID = rsp_valid_q;
  assign RSP       = rsp_q;

  // ============================================================
  // Operation sequencing
  always_comb begin
    st_d        = st_q;
    seq_d       = seq_q;
    step_d      = step_q;
    idx_d       = idx_q;
    sector_d    = sector_q;
    addr_d      = addr_q;
    pend_d      = issue ? 1'b1 : (eng_done ? 1'b0 : pend_q);
    ref_d       = ref_q;
    have_ref_d  = have_ref_q;
    tmr_d       = tmr_q + 1'b1;
    rsp_d       = rsp_q;
    rsp_valid_d = 1'b0;
    unique case (st_q)
      M_IDLE: begin
        tmr_d = '0;
        if (CMD_VALID) begin
          addr_d     = CMD_ADDR;
          sector_d   = CMD_ADDR[15:SECT_LSB];
          step_d     = 2'd0;
          idx_d      = 7'd0;
          have_ref_d = 1'b0;
          rsp_d      = '0;
          unique case (CMD_OP)
            OP_PROG:  begin
              seq_d = SEQ_PROG;
              st_d  = M_UNLOCK;
            end
            OP_IDENT: begin
              seq_d = SEQ_ID_IN;
              st_d  = M_UNLOCK;
            end
            default:  st_d = M_READ;
          endcase
        end
      end
      M_UNLOCK: begin
        // Every program re-unlocks: the part relocks itself after
        if (eng_done) begin
          step_d = step_q + 2'd1;
          if (step_q == 2'd2) begin
            step_d = 2'd0;
            tmr_d  = '0;
            unique case (seq_q)
              SEQ_PROG:  st_d = M_LOAD;
              SEQ_ID_IN: st_d = M_IDRD;
              default:   st_d = M_FIN;
            endcase
          end
        end
      end
      M_LOAD: begin
        if (issue) begin
          tmr_d = '0;
        end
        if (eng_done) begin
          idx_d = idx_q + 7'd1;
          if (idx_q == LAST_BYTE) begin
            st_d  = M_POLL;
            tmr_d = '0;
          end
        end else if (!pend_q && tmr_q >= BLC_LIMIT) begin
          // Source starved: the part will start on a short sector
          rsp_d.err = 1'b1;
          st_d      = M_FIN;
        end
      end
      M_POLL: begin
        // First read only seeds the reference; two equal reads end
        if (eng_done) begin
          ref_d      = toggle;
          have_ref_d = 1'b1;
          if (have_ref_q && toggle == ref_q) begin
            st_d = M_FIN;
          end else if (tmr_q >= WC_LIMIT) begin
            rsp_d.err = 1'b1;
            st_d      = M_FIN;
          end
        end
      end
      M_IDRD: begin
        if (eng_done) begin
          idx_d = 7'd1;
          if (idx_q[0]) begin
            rsp_d.part = eng_rdata;
            seq_d      = SEQ_ID_OUT;
            step_d     = 2'd0;
            st_d       = M_UNLOCK;
          end else begin
            rsp_d.data = eng_rdata;
          end
        end
      end
      M_READ: begin
        if (eng_done) begin
          rsp_d.data = eng_rdata;
          st_d       = M_FIN;
        end
      end
      M_FIN: begin
        rsp_valid_d = 1'b1;
        st_d        = M_IDLE;
      end
      default: st_d = M_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      st_q        <= M_IDLE;
      seq_q       <= SEQ_PROG;
      step_q      <= 2'd0;
      idx_q       <= 7'd0;
      sector_q    <= 9'h000;
      addr_q      <= 16'h0000;
      pend_q      <= 1'b0;
      ref_q       <= 1'b0;
      have_ref_q  <= 1'b0;
      tmr_q       <= '0;
      rsp_q       <= '0;
      rsp_valid_q <= 1'b0;
    end else begin
      st_q        <= st_d;
      seq_q       <= seq_d;
      step_q      <= step_d;
      idx_q       <= idx_d;
      sector_q    <= sector_d;
      addr_q      <= addr_d;
      pend_q      <= pend_d;
      ref_q       <= ref_d;
      have_ref_q  <= have_ref_d;
      tmr_q       <= tmr_d;
      rsp_q       <= rsp_d;
      rsp_valid_q <= rsp_valid_d;
    end
  end

  // ============================================================
  // Pin cycle engine
  sp_cycle u_cycle (
    .clk   (MCLK),
    .rst_n (RSTN),
    .req   (issue),
    .wr    (eng_wr),
    .addr  (eng_addr),
    .wdata (eng_wdata),
    .ready (eng_ready),
    .done  (eng_done),
    .rdata (eng_rdata),
    .pins  (FL_PINS),
    .dq_i  (FL_DQ_I)
  );

endmodule

// ### sp_flash_host_properties.sv
`timescale 1ns/1ps
// ============================================================
// Pin-level checks on the flash host
module sp_flash_host_chk
  import sp_pkg::*;
#(
  parameter int          BLC_CYCLES    = 200,
  parameter int          WC_CYCLES     = 2000,
  parameter logic [14:0] UNLOCK_ADDR_A = 15'h0001,
  parameter logic [7:0]  CODE_PROG     = 8'h03
) (
  input wire logic             MCLK,
  input wire logic             RSTN,
  input wire logic             CMD_VALID,
  input wire logic             CMD_READY,
  input wire sp_pkg::sp_op_t   CMD_OP,
  input wire logic [15:0]      CMD_ADDR,
  input wire logic             WR_VALID,
  input wire logic             WR_READY,
  input wire logic [7:0]       WR_DATA,
  input wire logic             RSP_VALID,
  input wire sp_pkg::sp_rsp_t  RSP,
  input wire sp_pkg::sp_pins_t FL_PINS,
  input wire logic [7:0]       FL_DQ_I
);
  logic       in_prog_q;
  logic       we_q;
  logic [8:0] sect_q;
  logic [8:0] nwr_q;
  int         gap_q;
  wire        take  = CMD_VALID && CMD_READY;
  wire        wfall = we_q && !FL_PINS.we_n;

  // Count write strobes of a program command and the gap between them
  always_ff @(posedge MCLK) begin
    we_q  <= !RSTN | FL_PINS.we_n;
    gap_q <= (!RSTN || wfall) ? 0 : gap_q + 1;
    if (!RSTN || take) begin
      in_prog_q <= RSTN && CMD_OP == OP_PROG;
      sect_q    <= CMD_ADDR[15:7];
      nwr_q     <= 9'h000;
    end else begin
      nwr_q     <= nwr_q + 9'(wfall);
      in_prog_q <= in_prog_q && !RSP_VALID;
    end
  end

  // ============================================================
  // Properties
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);

  property p_oe_high;
    (!FL_PINS.we_n && !FL_PINS.ce_n) |-> FL_PINS.oe_n;
  endproperty
  a_oe_high: assert property (p_oe_high)
    else $error("output enable low during a write");
  property p_unlock_code;
    (in_prog_q && wfall && nwr_q == 9'h002) |->
      (FL_PINS.dq_o == CODE_PROG && FL_PINS.addr[14:0] == UNLOCK_ADDR_A);
  endproperty
  a_unlock_code: assert property (p_unlock_code)
    else $error("third unlock write wrong");
  property p_cmd_addr;
    (in_prog_q && wfall && nwr_q < 9'h003) |-> !FL_PINS.addr[15];
  endproperty
  a_cmd_addr: assert property (p_cmd_addr)
    else $error("unlock write drives top address bit");
  property p_sector;
    (in_prog_q && wfall && nwr_q >= 9'h003) |->
      FL_PINS.addr[15:7] == sect_q;
  endproperty
  a_sector: assert property (p_sector)
    else $error("load write outside target sector");
  property p_all_bytes;
    (RSP_VALID && in_prog_q && !RSP.err) |-> nwr_q == 9'h083;
  endproperty
  a_all_bytes: assert property (p_all_bytes)
    else $error("program ended without a full sector");
  property p_load_gap;
    (in_prog_q && wfall && nwr_q >= 9'h004) |-> gap_q < BLC_CYCLES;
  endproperty
  a_load_gap: assert property (p_load_gap)
    else $error("byte loads too far apart");
  property p_poll_addr;
    (in_prog_q && nwr_q == 9'h083 && !FL_PINS.oe_n) |->
      FL_PINS.addr == {sect_q, LAST_BYTE};
  endproperty
  a_poll_addr: assert property (p_poll_addr)
    else $error("poll address moved");
  property p_addr_hold;
    wfall |=> $stable(FL_PINS.addr)[*8];
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address changed during write pulse");

  c_prog_ok:  cover property (RSP_VALID && in_prog_q && !RSP.err);
  c_prog_err: cover property (RSP_VALID && in_prog_q && RSP.err);
  c_poll:     cover property (in_prog_q && nwr_q == 9'h083 && !FL_PINS.oe_n);
endmodule

bind sp_flash_host sp_flash_host_chk #(
  .BLC_CYCLES(BLC_CYCLES), .WC_CYCLES(WC_CYCLES),
  .UNLOCK_ADDR_A(UNLOCK_ADDR_A), .CODE_PROG(CODE_PROG)
) u_chk (
  .MCLK(MCLK), .RSTN(RSTN), .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY),
  .CMD_OP(CMD_OP), .CMD_ADDR(CMD_ADDR), .WR_VALID(WR_VALID),
  .WR_READY(WR_READY), .WR_DATA(WR_DATA), .RSP_VALID(RSP_VALID),
  .RSP(RSP), .FL_PINS(FL_PINS), .FL_DQ_I(FL_DQ_I)
);

// ### sp_flash_host_tb_top.sv
`timescale 1ns/1ps
// ============================================================
// Self-checking bench for the flash host
module sp_flash_host_tb_top;
  import sp_pkg::*;
  localparam logic [7:0] MAKER = 8'hA7;  // Arbitrary value
  localparam logic [7:0] PART  = 8'h5C;  // Arbitrary value
  logic        MCLK      = 1'b0;
  logic        RSTN      = 1'b0;
  logic        CMD_VALID = 1'b0;
  logic        WR_VALID  = 1'b0;
  sp_op_t      CMD_OP    = OP_READ;
  logic [15:0] CMD_ADDR  = 16'h0000;
  logic [15:0] plen      = 16'h0258;
  logic [7:0]  WR_DATA   = 8'h00;
  logic [7:0]  dq;
  logic        CMD_READY;
  logic        WR_READY;
  logic        RSP_VALID;
  sp_rsp_t     RSP;
  sp_pins_t    FL_PINS;
  int          miscompares = 0;
  int          n_checks = 0;

  always #2.5 MCLK = ~MCLK;

  // Short windows keep each program run brief
  sp_flash_host #(.BLC_CYCLES(200), .WC_CYCLES(2000)) dut (
    .MCLK(MCLK), .RSTN(RSTN), .CMD_VALID(CMD_VALID),
    .CMD_READY(CMD_READY), .CMD_OP(CMD_OP), .CMD_ADDR(CMD_ADDR),
    .WR_VALID(WR_VALID), .WR_READY(WR_READY), .WR_DATA(WR_DATA),
    .RSP_VALID(RSP_VALID), .RSP(RSP), .FL_PINS(FL_PINS), .FL_DQ_I(dq));
  sp_flash_model #(.MAKER_ID(MAKER), .PART_ID(PART)) u_flash (
    .clk(MCLK), .pins(FL_PINS), .prog_len(plen), .dq(dq));

  function automatic logic [7:0] pat(input logic [7:0] s, input int i);
    return s ^ 8'(i * 3);
  endfunction

  task automatic chk(input string nm, input logic [27:0] e, g);
    n_checks++;
    if (g !== e) begin
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      miscompares++;
    end
  endtask

  task automatic give_verdict;
    if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // One command, nb bytes streamed, then wait for the response pulse
  task automatic run(input sp_op_t op, input logic [15:0] a, input int nb,
                     input logic [7:0] s, output sp_rsp_t r);
    int n;
    CMD_VALID <= 1'b1;
    CMD_OP    <= op;
    CMD_ADDR  <= a;
    do @(posedge MCLK); while (!CMD_READY);
    CMD_VALID <= 1'b0;
    for (n = 0; n < nb; n++) begin
      WR_VALID <= 1'b1;
      WR_DATA  <= pat(s, n);
      do @(posedge MCLK); while (!WR_READY);
    end
    WR_VALID <= 1'b0;
    for (n = 0; n < 30000 && !RSP_VALID; n++) @(posedge MCLK);
    r = RSP;
  endtask

  task automatic t_reset;
    chk("idle_pins", {3'b111, 24'h000000, 1'b1}, FL_PINS);
    chk("idle_ports", {3'b100, 17'h00000}, {CMD_READY, WR_READY,
        RSP_VALID, RSP});
  endtask

  // Full sector, then read first, middle and last offset back
  task automatic t_prog_ok;
    sp_rsp_t r;
    sp_op_t  op;
    logic [6:0] o;
    run(OP_PROG, 16'h1280, 128, 8'h5A, r);
    chk("prog_err", 28'h0, r.err);
    for (int i = 0; i < 3; i++) begin
      o  = (i == 2) ? 7'h7F : 7'(i * 64);
      op = (i == 2) ? sp_op_t'(2'b11) : OP_READ;
      run(op, {9'h025, o}, 0, 8'h00, r);
      chk("readback", pat(8'h5A, int'(o)), r.data);
    end
  endtask

  // Identification bytes, then the array is readable again
  task automatic t_ident;
    sp_rsp_t r;
    run(OP_IDENT, 16'hFFFF, 0, 8'h00, r);
    chk("maker", MAKER, r.data);
    chk("part", PART, r.part);
    run(OP_READ, 16'h1281, 0, 8'h00, r);
    chk("after_id", pat(8'h5A, 1), r.data);
  endtask

  // Device slower than the host's program limit
  task automatic t_slow;
    sp_rsp_t r;
    plen <= 16'h1388;
    run(OP_PROG, 16'hFF80, 128, 8'hC3, r);
    chk("slow_err", 28'h1, r.err);
    repeat (6000) @(posedge MCLK);
  endtask

  // Byte source stops after two loads
  task automatic t_starve;
    sp_rsp_t r;
    plen <= 16'h0258;
    run(OP_PROG, 16'h0100, 2, 8'h33, r);
    chk("starve_err", 28'h1, r.err);
    repeat (1000) @(posedge MCLK);
  endtask

  initial begin
    repeat (80000) @(posedge MCLK);
    miscompares++;
    give_verdict;
  end

  initial begin
    repeat (2) @(posedge MCLK);
    RSTN <= 1'b1;
    @(posedge MCLK);
    t_reset;
    t_prog_ok;
    t_ident;
    t_slow;
    t_starve;
    give_verdict;
  end
endmodule

// ### sp_flash_model.sv
`timescale 1ns/1ps
// ============================================================
// Behavioural flash device on the host pins
module sp_flash_model
  import sp_pkg::*;
#(
  parameter int          WIN      = 200,
  parameter logic [7:0]  MAKER_ID = 8'hA7,  // Arbitrary value
  parameter logic [7:0]  PART_ID  = 8'h5C,  // Arbitrary value
  parameter logic [14:0] UA_ADDR  = 15'h0001,
  parameter logic [14:0] UB_ADDR  = 15'h0002
) (
  input  wire logic             clk,
  input  wire sp_pkg::sp_pins_t pins,
  input  wire logic [15:0]      prog_len,
  output logic [7:0]            dq
);
  logic [7:0]   mem [0:65535];
  logic [7:0]   page [0:127];
  logic [127:0] got;
  logic [1:0]   step = 2'h0;
  logic         loading = 1'b0;
  logic         ident = 1'b0;
  logic         busy = 1'b0;
  logic         tog = 1'b0;
  logic         b7 = 1'b0;
  logic         we_q = 1'b1;
  logic         rd_q = 1'b0;
  logic [8:0]   sect;
  logic [7:0]   last = 8'h00;
  int           tmr = 0;
  wire [15:0]   a      = pins.addr;
  wire          rd     = !pins.ce_n && !pins.oe_n;
  wire          rd_go  = rd && !rd_q;
  wire          wr_end = !we_q && pins.we_n && !pins.ce_n;
  wire          hit_a  = a[14:0] == UA_ADDR;
  wire [7:0]    stat   = {~b7, tog, 6'h00};
  wire [7:0]    idv    = a[0] ? PART_ID : MAKER_ID;
  wire          id_hit = ident && a[15:1] == 15'h0000;
  wire [7:0]    dout   = (busy || loading) ? stat : id_hit ? idv : mem[a];
  // A released bus changes every cycle so stale data is never trusted
  assign dq = !pins.dq_oe_n ? pins.dq_o : rd ? dout : ~last;

  // Unlock decoding, byte loads and the timed program cycle
  always @(posedge clk) begin
    we_q <= pins.we_n;
    rd_q <= rd;
    last <= dq;
    if (busy) begin
      tmr <= tmr + 1;
      if (rd_go) tog <= ~tog;
      if (tmr >= prog_len) begin
        busy <= 1'b0;
        for (int k = 0; k < 128; k++)
          mem[{sect, 7'(k)}] <= got[k] ? page[k] : 8'hXX;
      end
    end else if (loading && (tmr >= WIN || rd_go)) begin
      loading <= 1'b0;
      busy    <= 1'b1;
      tmr     <= 0;
    end else if (loading) begin
      tmr <= tmr + 1;
    end
    if (wr_end && loading) begin
      page[a[6:0]] <= pins.dq_o;
      got[a[6:0]]  <= 1'b1;
      sect         <= a[15:7];
      b7           <= pins.dq_o[7];
      tmr          <= 0;
    end else if (wr_end && !busy) begin
      step <= 2'h0;
      if (step == 2'h0 && hit_a && pins.dq_o == 8'h01) step <= 2'h1;
      if (step == 2'h1 && a[14:0] == UB_ADDR && pins.dq_o == 8'h02)
        step <= 2'h2;
      if (step == 2'h2 && hit_a) begin
        loading <= pins.dq_o == 8'h03;
        got     <= '0;
        tmr     <= 0;
        if (pins.dq_o == 8'h04) ident <= 1'b1;
        if (pins.dq_o == 8'h05) ident <= 1'b0;
      end
    end
  end
endmodule

// ### sp_pkg.sv
// ============================================================
// Shared constants and types for the sector program host
package sp_pkg;

  // ============================================================
  // Clock and pin timing
  localparam int CLK_MHZ     = 200;
  localparam int T_AS_NS     = 10;   // Address and OE set-up
  localparam int T_WP_NS     = 200;  // Write pulse low
  localparam int T_WPH_NS    = 200;  // Write pulse high
  localparam int T_ACC_NS    = 250;  // Read access, slowest grade
  localparam int T_OEHP_NS   = 150;  // OE high pulse between polls
  localparam int T_BLC_US    = 150;  // Byte load window, longest
  localparam int T_WC_MS     = 20;   // Program cycle, longest
  localparam int SYNC_STAGES = 2;

  // Least times round up to whole cycles, never below one
  function automatic int ns_up(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int AS_CYC   = ns_up(T_AS_NS);
  localparam int WP_CYC   = ns_up(T_WP_NS);
  localparam int WPH_CYC  = ns_up(T_WPH_NS);
  localparam int ACC_CYC  = ns_up(T_ACC_NS);
  localparam int OEHP_CYC = ns_up(T_OEHP_NS);
  // Longest times round down
  localparam int BLC_CYC  = T_BLC_US * CLK_MHZ;
  localparam int WC_CYC   = T_WC_MS * 1000 * CLK_MHZ;
  localparam int LOAD_GUARD = AS_CYC + WP_CYC + WPH_CYC + 2;

  // ============================================================
  // Array layout
  localparam int          SECTOR_BYTES  = 128;
  localparam int          SECT_LSB      = 7;
  localparam int          TOGGLE_BIT    = 6;
  localparam logic [15:0] ID_MAKER_ADDR = 16'h0000;
  localparam logic [15:0] ID_PART_ADDR  = 16'h0001;
  localparam logic [6:0]  LAST_BYTE     = 7'h7F;
  localparam int          CNT_W         = 8;

  // ============================================================
  // Types
  typedef enum logic [1:0] {
    OP_READ  = 2'b00,
    OP_PROG  = 2'b01,
    OP_IDENT = 2'b10
  } sp_op_t;

  typedef enum logic [1:0] {
    SEQ_PROG   = 2'b00,
    SEQ_ID_IN  = 2'b01,
    SEQ_ID_OUT = 2'b10
  } sp_seq_t;

  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [15:0] addr;
    logic [7:0]  dq_o;
    logic        dq_oe_n;
  } sp_pins_t;

  typedef struct packed {
    logic       err;
    logic [7:0] data;
    logic [7:0] part;
  } sp_rsp_t;

endpackage
